// [hw/alarm_command_handler.sv]
// Command decoder, alarm store and output port logic of the threshold alarm handler.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
// How it works
// RULE1 - Set-low frame: address, opcode, limit, channel, type, port.
// RULE2 - Two hex address chars; act only on own.
// RULE3 - Limit is sign, three digits, point, two.
// RULE4 - Type letter M momentary, L latched, stored.
// RULE5 - Accepted replies bang plus address, else question.
// RULE6 - Bad syntax, line error, foreign address: silence.
// RULE7 - Port on while any tied alarm active.
// RULE8 - Active read replies high byte then low.
// RULE9 - High byte bit n: channel n high active.
// RULE10 - Low byte bit n: channel n low active.
// RULE11 - Missing port on active read answers invalid.
// RULE12 - High read returns limit, type code, port.
// RULE13 - Low read returns same layout for low.
// RULE14 - Type code: 0 off, 1 momentary, 2 latched.
// RULE15 - Returned limit has explicit sign and point.
// RULE16 - Limits use selected scale, Celsius by default; the scale bit is stored but never applied.
// RULE17 - Latched low alarm holds until clear command.
// RULE18 - Direct writes ignored on alarm-assigned ports.
// RULE19 - Optional check pair before return; mismatch rejected.
// RULE20 - Low below limit, high above limit activate.
module alarm_command_handler
  import alarm_pkg::*;
#(
  parameter int N_CH = N_CH_DEF,
  parameter int N_DO = N_DO_DEF,
  parameter logic [7:0] ADDR_RST = ADDR_RST_DEF
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RSTN,
  // Received characters from the line receiver.
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_ERR,
  // Transmitted characters to the line transmitter.
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  // Readings in signed hundredths of a degree.
  input wire logic [N_CH-1:0][TEMP_W-1:0] TEMP_IN,
  // Output ports.
  output logic [N_DO-1:0] DO_OUT,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);

  typedef struct packed {
    logic [BUF_N-1:0][7:0] rx_buf; // Characters of the frame in progress.
    logic [4:0] cnt; // Characters held.
    logic bad; // Overflow or line error seen in this frame.
    logic [7:0] sum; // Running sum of the frame's characters, overflow ones included.
    logic [N_CH-1:0][LIM_W-1:0] lo_lim; // Low limits, sign and BCD.
    logic [N_CH-1:0][LIM_W-1:0] hi_lim; // High limits, sign and BCD.
    logic [N_CH-1:0][1:0] lo_typ; // Low alarm types.
    logic [N_CH-1:0][1:0] hi_typ; // High alarm types.
    logic [N_CH-1:0][CH_W-1:0] lo_prt; // Low alarm ports.
    logic [N_CH-1:0][CH_W-1:0] hi_prt; // High alarm ports.
    logic [N_CH-1:0] lo_act; // Active low alarms.
    logic [N_CH-1:0] hi_act; // Active high alarms.
    logic [7:0] addr; // Own module address.
    logic cks_en; // Check characters in use.
    logic scale; // Temperature scale select, zero for Celsius.
    logic [N_DO-1:0] do_wr; // Directly written port values.
    logic [N_DO-1:0] do_out; // Port drive.
    logic [31:0] rdata; // Register read data.
    logic rep_go; // Reply start pulse.
    logic [REP_N-1:0][7:0] rep_chars; // Reply body.
    logic [4:0] rep_len; // Reply length.
  } state_t;

  state_t q; // Registered state.
  state_t n; // Next state.
  reply_if rif ();

  // Frame decode and alarm evaluation.
  always_comb begin
    logic [4:0] blen;
    logic ck_ok;
    logic frame_ok;
    logic send;
    logic ack;
    logic [4:0] a1;
    logic [4:0] a0;
    logic [4:0] k1;
    logic [4:0] k0;
    logic [7:0] bsum;
    logic [15:0] op;
    logic [7:0] sel_c;
    logic [7:0] arg_c;
    logic sel_ok;
    logic arg_ok;
    logic [CH_W-1:0] hc;
    logic [LIM_W-1:0] rlim;
    logic [1:0] rt;
    logic [CH_W-1:0] rp;
    logic [7:0] active_high_mask;
    logic [7:0] active_low_mask;
    logic [REP_N-1:0][7:0] rep;
    logic [4:0] rlen;
    logic [N_CH-1:0] lo_new;
    logic [N_CH-1:0] lo_clr;
    logic [N_CH-1:0] hi_new;
    logic cond;
    logic asg;
    logic on;
    n = q;
    n.rep_go = 1'b0;
    lo_new = '0;
    lo_clr = '0;
    hi_new = '0;
    hc = REG_WDATA[HI_CH_LSB +: CH_W];
    // Register writes; the high limit register loads one channel.
    if (REG_WR) begin
      unique case (REG_ADDR)
        R_ADDR: n.addr = REG_WDATA[7:0];
        R_CTRL: begin
          n.cks_en = REG_WDATA[CTRL_CKS];
          n.scale = REG_WDATA[CTRL_SCALE]; // see RULE16
        end
        R_HIGH: begin
          if (32'(hc) < N_CH) begin
            n.hi_lim[hc] = REG_WDATA[LIM_W-1:0];
            n.hi_typ[hc] = REG_WDATA[HI_TYP_LSB +: 2];
            n.hi_prt[hc] = REG_WDATA[HI_PRT_LSB +: CH_W];
            hi_new[hc] = 1'b1;
          end
        end
        R_DOWR: n.do_wr = REG_WDATA[N_DO-1:0];
        default: ;
      endcase
    end
    // Read data stands only in the cycle after the strobe.
    n.rdata = 32'h0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        R_ADDR: n.rdata = 32'(q.addr);
        R_CTRL: n.rdata = 32'({q.scale, q.cks_en});
        R_STAT: n.rdata = (32'(q.do_out) << ST_DO_LSB) | 32'({q.hi_act, q.lo_act});
        default: n.rdata = 32'h0;
      endcase
    end
    // Check field and address of the held frame.
    blen = q.cnt;
    ck_ok = 1'b1;
    k1 = 5'h00;
    k0 = 5'h00;
    bsum = q.sum;
    if (q.cks_en) begin
      if (q.cnt < 5'h02) begin
        ck_ok = 1'b0;
      end else begin
        blen = q.cnt - 5'h02;
        k1 = hex_val(q.rx_buf[blen]);
        k0 = hex_val(q.rx_buf[blen + 5'h01]);
        bsum = q.sum - q.rx_buf[blen] - q.rx_buf[blen + 5'h01];
        ck_ok = k1[4] && k0[4] && ({k1[3:0], k0[3:0]} == bsum); // see RULE19
      end
    end
    a1 = hex_val(q.rx_buf[P_AH]);
    a0 = hex_val(q.rx_buf[P_AL]);
    frame_ok = !q.bad && !RX_ERR && ck_ok && blen >= LEN_SHORT && q.rx_buf[0] == CH_AT &&
               a1[4] && a0[4] && {a1[3:0], a0[3:0]} == q.addr; // see RULE2 see RULE6
    op = {q.rx_buf[P_OPH], q.rx_buf[P_OPL]};
    sel_c = q.rx_buf[P_SEL + 1];
    arg_c = q.rx_buf[P_ARG + 1];
    sel_ok = is_dig(sel_c) && 32'(sel_c[3:0]) < N_CH;
    arg_ok = is_dig(arg_c);
    rlim = (op == read_high_settings_op) ? q.hi_lim[arg_c[CH_W-1:0]] : q.lo_lim[arg_c[CH_W-1:0]];
    rt = (op == read_high_settings_op) ? q.hi_typ[arg_c[CH_W-1:0]] : q.lo_typ[arg_c[CH_W-1:0]];
    rp = (op == read_high_settings_op) ? q.hi_prt[arg_c[CH_W-1:0]] : q.lo_prt[arg_c[CH_W-1:0]];
    active_high_mask = 8'h00;
    active_low_mask = 8'h00;
    for (int c = 0; c < N_CH; c++) begin
      active_high_mask[c] = q.hi_act[c] && q.hi_prt[c] == arg_c[CH_W-1:0]; // see RULE9
      active_low_mask[c] = q.lo_act[c] && q.lo_prt[c] == arg_c[CH_W-1:0]; // see RULE10
    end
    rep = '0;
    rep[P_AH] = hex_chr(q.addr[7:4]);
    rep[P_AL] = hex_chr(q.addr[3:0]);
    rlen = 5'h03;
    send = 1'b0;
    ack = 1'b0;
    // A finished frame is decoded only while the serialiser is free.
    if (RX_VALID && RX_DATA == CH_CR && frame_ok && !q.rep_go && !rif.busy) begin
      unique case (op)
        set_low_threshold_op: begin
          if (blen == LEN_SET && (q.rx_buf[P_SIGN] == CH_PLUS || q.rx_buf[P_SIGN] == CH_MINUS) &&
              is_dig(q.rx_buf[P_SIGN + 1]) && is_dig(q.rx_buf[P_SIGN + 2]) &&
              is_dig(q.rx_buf[P_SIGN + 3]) && q.rx_buf[P_DOT] == CH_DOT &&
              is_dig(q.rx_buf[P_DOT + 1]) && is_dig(q.rx_buf[P_DOT + 2]) &&
              q.rx_buf[P_SEL] == CH_C && is_dig(sel_c) &&
              (q.rx_buf[P_SEL + 2] == CH_M || q.rx_buf[P_SEL + 2] == CH_L) &&
              q.rx_buf[P_SEL + 3] == CH_O && is_dig(q.rx_buf[P_SEL + 4])) begin // see RULE1 see RULE3
            send = 1'b1;
            if (sel_ok && 32'(q.rx_buf[P_SEL + 4][3:0]) < N_DO) begin
              ack = 1'b1;
              n.lo_lim[sel_c[CH_W-1:0]] = {q.rx_buf[P_SIGN] == CH_MINUS, q.rx_buf[P_SIGN + 1][3:0],
                                           q.rx_buf[P_SIGN + 2][3:0], q.rx_buf[P_SIGN + 3][3:0],
                                           q.rx_buf[P_DOT + 1][3:0], q.rx_buf[P_DOT + 2][3:0]};
              n.lo_typ[sel_c[CH_W-1:0]] = (q.rx_buf[P_SEL + 2] == CH_L) ? TY_LAT : TY_MOM; // see RULE4
              n.lo_prt[sel_c[CH_W-1:0]] = q.rx_buf[P_SEL + 4][CH_W-1:0];
              lo_new[sel_c[CH_W-1:0]] = 1'b1;
            end
          end
        end
        read_active_alarms_op: begin
          if (blen == LEN_SHORT && q.rx_buf[P_ARG] == CH_O && arg_ok) begin
            send = 1'b1;
            if (32'(arg_c[3:0]) < N_DO) begin // see RULE11
              ack = 1'b1;
              rep[3] = hex_chr(active_high_mask[7:4]); // see RULE8
              rep[4] = hex_chr(active_high_mask[3:0]);
              rep[5] = hex_chr(active_low_mask[7:4]);
              rep[6] = hex_chr(active_low_mask[3:0]);
              rlen = 5'h07;
            end
          end
        end
        read_high_settings_op, read_low_settings_op: begin
          if (blen == LEN_SHORT && q.rx_buf[P_ARG] == CH_C && arg_ok) begin
            send = 1'b1;
            if (32'(arg_c[3:0]) < N_CH) begin // see RULE12 see RULE13
              ack = 1'b1;
              rep[3] = rlim[20] ? CH_MINUS : CH_PLUS; // see RULE15
              rep[4] = {4'h3, rlim[19:16]};
              rep[5] = {4'h3, rlim[15:12]};
              rep[6] = {4'h3, rlim[11:8]};
              rep[7] = CH_DOT;
              rep[8] = {4'h3, rlim[7:4]};
              rep[9] = {4'h3, rlim[3:0]};
              rep[10] = {6'h0c, rt}; // see RULE14
              rep[11] = CH_O;
              rep[12] = {5'h06, rp};
              rlen = 5'(REP_N);
            end
          end
        end
        clear_low_latch_op: begin
          if (blen == LEN_SHORT && q.rx_buf[P_ARG] == CH_C && arg_ok) begin
            send = 1'b1;
            if (32'(arg_c[3:0]) < N_CH) begin
              ack = 1'b1;
              lo_clr[arg_c[CH_W-1:0]] = 1'b1; // see RULE17
            end
          end
        end
        default: send = 1'b1; // Unknown command on a good frame.
      endcase
    end
    rep[0] = ack ? CH_OK : CH_NG; // see RULE5
    if (send) begin
      n.rep_go = 1'b1;
      n.rep_chars = rep;
      n.rep_len = rlen;
    end
    // Character collection; a return ends the frame whatever its fate.
    if (RX_VALID) begin
      if (RX_DATA == CH_CR) begin
        n.cnt = 5'h00;
        n.bad = 1'b0;
        n.sum = 8'h00;
      end else begin
        if (q.cnt == 5'(BUF_N)) begin
          n.bad = 1'b1;
        end else begin
          n.rx_buf[q.cnt] = RX_DATA;
          n.cnt = q.cnt + 5'h01;
        end
        n.sum = q.sum + RX_DATA;
        if (RX_ERR) begin
          n.bad = 1'b1; // see RULE6
        end
      end
    end
    // Alarm states; a detection in a clearing cycle still sets the latch.
    for (int c = 0; c < N_CH; c++) begin
      cond = q.lo_typ[c] != TY_OFF && $signed(TEMP_IN[c]) < lim_bin(q.lo_lim[c]); // see RULE20
      if (lo_new[c]) begin
        n.lo_act[c] = 1'b0;
      end else if (q.lo_typ[c] == TY_LAT) begin
        n.lo_act[c] = (q.lo_act[c] && !lo_clr[c]) || cond; // see RULE17
      end else begin
        n.lo_act[c] = cond;
      end
      cond = q.hi_typ[c] != TY_OFF && $signed(TEMP_IN[c]) > lim_bin(q.hi_lim[c]); // see RULE20
      if (hi_new[c]) begin
        n.hi_act[c] = 1'b0;
      end else if (q.hi_typ[c] == TY_LAT) begin
        n.hi_act[c] = q.hi_act[c] || cond;
      end else begin
        n.hi_act[c] = cond;
      end
    end
    // Port drive: alarm ports follow their alarms, others the direct value.
    for (int p = 0; p < N_DO; p++) begin
      asg = 1'b0;
      on = 1'b0;
      for (int c = 0; c < N_CH; c++) begin
        if (q.lo_typ[c] != TY_OFF && q.lo_prt[c] == CH_W'(p)) begin
          asg = 1'b1;
          on = on | q.lo_act[c];
        end
        if (q.hi_typ[c] != TY_OFF && q.hi_prt[c] == CH_W'(p)) begin
          asg = 1'b1;
          on = on | q.hi_act[c];
        end
      end
      n.do_out[p] = asg ? on : q.do_wr[p]; // see RULE7 see RULE18
    end
  end

  // Registers all state with a synchronous reset.
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      q <= '0;
      q.addr <= ADDR_RST;
    end else begin
      q <= n;
    end
  end

  // Reply serialiser.
  reply_sender u_send (
    .clk(MCLK),
    .rst_n(RSTN),
    .rif(rif.snd)
  );

  assign rif.go = q.rep_go;
  assign rif.chars = q.rep_chars;
  assign rif.len = q.rep_len;
  assign rif.cks_en = q.cks_en;
  assign rif.tx_ready = TX_READY;
  assign TX_DATA = rif.tx_data;
  assign TX_VALID = rif.tx_valid;
  assign DO_OUT = q.do_out;
  assign REG_RDATA = q.rdata;

endmodule // alarm_command_handler

// [include/alarm_pkg.sv]
// Shared constants, character codes and helper functions of the alarm command handler.
package alarm_pkg;

  // Default sizes of the channel set, output ports and buffers.
  localparam int N_CH_DEF = 8;
  localparam int N_DO_DEF = 8;
  localparam int CH_W = 3;
  localparam int BUF_N = 20;
  localparam int REP_N = 13;
  localparam int LIM_W = 21;
  localparam int TEMP_W = 18;

  // Frame characters.
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_OK = 8'h21;
  localparam logic [7:0] CH_NG = 8'h3f;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_L = 8'h4c;

  // Two-letter opcodes as character pairs.
  localparam logic [15:0] set_low_threshold_op = 16'h4c4f;
  localparam logic [15:0] read_active_alarms_op = 16'h5241;
  localparam logic [15:0] read_high_settings_op = 16'h5248;
  localparam logic [15:0] read_low_settings_op = 16'h524c;
  localparam logic [15:0] clear_low_latch_op = 16'h434c;

  // Frame lengths without check characters, and field positions.
  localparam logic [4:0] LEN_SET = 5'h11;
  localparam logic [4:0] LEN_SHORT = 5'h07;
  localparam int P_AH = 1;
  localparam int P_AL = 2;
  localparam int P_OPH = 3;
  localparam int P_OPL = 4;
  localparam int P_SIGN = 5;
  localparam int P_DOT = 9;
  localparam int P_SEL = 12;
  localparam int P_ARG = 5;

  // Stored alarm type codes, also the readback codes.
  localparam logic [1:0] TY_OFF = 2'h0;
  localparam logic [1:0] TY_MOM = 2'h1;
  localparam logic [1:0] TY_LAT = 2'h2;

  // Register offsets and field positions.
  localparam logic [7:0] R_ADDR = 8'h00;
  localparam logic [7:0] R_CTRL = 8'h04;
  localparam logic [7:0] R_HIGH = 8'h08;
  localparam logic [7:0] R_DOWR = 8'h0c;
  localparam logic [7:0] R_STAT = 8'h10;
  localparam int CTRL_CKS = 0;
  localparam int CTRL_SCALE = 1;
  localparam int HI_TYP_LSB = 21;
  localparam int HI_PRT_LSB = 23;
  localparam int HI_CH_LSB = 26;
  localparam int ST_DO_LSB = 16;
  localparam logic [7:0] ADDR_RST_DEF = 8'h01;

  // Decodes one hex character; bit 4 flags a legal character.
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b1, c[3:0] + 4'h9};
    return 5'h00;
  endfunction

  // Encodes one nibble as an upper-case hex character.
  function automatic logic [7:0] hex_chr(input logic [3:0] v);
    return (v < 4'ha) ? {4'h3, v} : {4'h4, v - 4'h9};
  endfunction

  // True for a decimal digit character.
  function automatic logic is_dig(input logic [7:0] c);
    return c >= CH_0 && c <= CH_9;
  endfunction

  // Converts a stored sign plus five BCD digits to signed hundredths.
  function automatic logic signed [TEMP_W-1:0] lim_bin(input logic [LIM_W-1:0] l);
    logic [TEMP_W-1:0] m;
    m = TEMP_W'(l[19:16]) * 18'd10000 + TEMP_W'(l[15:12]) * 18'd1000 +
        TEMP_W'(l[11:8]) * 18'd100 + TEMP_W'(l[7:4]) * 18'd10 + TEMP_W'(l[3:0]);
    return l[20] ? -$signed(m) : $signed(m);
  endfunction

endpackage

// [include/reply_if.sv]
// Carrier between the command decoder and the reply serialiser.
`timescale 1ns/1ns
interface reply_if;
  import alarm_pkg::*;
  logic go; // One-cycle start of a reply.
  logic [REP_N-1:0][7:0] chars; // Reply body, held while busy.
  logic [4:0] len; // Number of body characters.
  logic cks_en; // Append two check characters.
  logic busy; // Serialiser owns the line.
  logic [7:0] tx_data; // Outgoing character.
  logic tx_valid; // Outgoing character is offered.
  logic tx_ready; // Transmitter takes the character.
  modport cmd (output go, chars, len, cks_en, tx_ready, input busy, tx_data, tx_valid);
  modport snd (input go, chars, len, cks_en, tx_ready, output busy, tx_data, tx_valid);
endinterface

// [hw/reply_sender.sv]
// Serialises a reply body, its optional check characters and the closing return.
`timescale 1ns/1ns
module reply_sender
  import alarm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Reply carrier.
  reply_if.snd rif
);

  typedef enum logic [2:0] {S_IDLE, S_BODY, S_CKH, S_CKL, S_TERM, S_DRAIN} snd_st_t;

  typedef struct packed {
    snd_st_t st;
    logic [4:0] idx;
    logic [7:0] sum;
    logic [7:0] data;
    logic valid;
  } snd_t;

  snd_t q; // Registered state.
  snd_t d; // Next state.
  logic adv; // The output slot is free for a new character.

  // Steps through the body, then the check pair, then the return.
  always_comb begin
    d = q;
    adv = !q.valid || rif.tx_ready;
    unique case (q.st)
      S_IDLE: begin
        if (rif.go) begin
          d.st = S_BODY;
          d.idx = 5'h00;
          d.sum = 8'h00;
        end
      end
      S_BODY: begin
        if (adv) begin
          d.data = rif.chars[q.idx];
          d.valid = 1'b1;
          d.sum = q.sum + rif.chars[q.idx];
          d.idx = q.idx + 5'h01;
          if (q.idx + 5'h01 == rif.len) begin
            d.st = rif.cks_en ? S_CKH : S_TERM; // see RULE19
          end
        end
      end
      S_CKH: begin
        if (adv) begin
          d.data = hex_chr(q.sum[7:4]);
          d.st = S_CKL;
        end
      end
      S_CKL: begin
        if (adv) begin
          d.data = hex_chr(q.sum[3:0]);
          d.st = S_TERM;
        end
      end
      S_TERM: begin
        if (adv) begin
          d.data = CH_CR;
          d.valid = 1'b1;
          d.st = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (adv) begin
          d.valid = 1'b0;
          d.st = S_IDLE;
        end
      end
    endcase
  end

  // Registers the state with a synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rif.busy = (q.st != S_IDLE);
  assign rif.tx_data = q.data;
  assign rif.tx_valid = q.valid;

endmodule // reply_sender

// [verification/alarm_checker.sv]
// Port-level assertions of the alarm command handler.
`timescale 1ns/1ns
module alarm_checker
  import alarm_pkg::*;
#(
  parameter int N_DO = N_DO_DEF
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RSTN,
  // Character link.
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_ERR,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  // Output ports.
  input wire logic [N_DO-1:0] DO_OUT,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA
);
  // All checks sample on the rising clock edge.
  default clocking cb @(posedge MCLK);
  endclocking

  a_reset_quiet: assert property (!RSTN |=> !TX_VALID && DO_OUT == '0 && REG_RDATA == '0)
    else $error("outputs not quiet in reset");
  a_rdata_pulse: assert property (disable iff (!RSTN) !REG_RD |=> REG_RDATA == '0)
    else $error("read data outside read answer");
  a_unmapped_rd: assert property (disable iff (!RSTN) REG_RD && REG_ADDR == 8'h14 |=> REG_RDATA == '0)
    else $error("unmapped read not zero");
  a_high_wonly: assert property (disable iff (!RSTN) REG_RD && REG_ADDR == R_HIGH |=> REG_RDATA == '0)
    else $error("write-only register read back");
  a_addr_rw: assert property (disable iff (!RSTN)
    REG_WR && REG_ADDR == R_ADDR ##1 REG_RD && REG_ADDR == R_ADDR |=> REG_RDATA[7:0] == $past(REG_WDATA[7:0], 2))
    else $error("address register lost write");
  a_ctrl_rw: assert property (disable iff (!RSTN)
    REG_WR && REG_ADDR == R_CTRL ##1 REG_RD && REG_ADDR == R_CTRL |=> REG_RDATA[1:0] == $past(REG_WDATA[1:0], 2))
    else $error("control register lost write");
  a_tx_hold: assert property (disable iff (!RSTN) TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("offered character dropped");
  a_err_silent: assert property (disable iff (!RSTN)
    RX_VALID && RX_DATA == CH_CR && RX_ERR && !TX_VALID |=> !TX_VALID [*4])
    else $error("reply to damaged frame");
endmodule // alarm_checker

// [verification/host_model.sv]
// Host model that sends command frames and gathers the replies.
`timescale 1ns/1ns
module host_model
  import alarm_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Characters to the device.
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  // Characters from the device.
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  int seed = 55; // Fixed seed of the ready stalls.
  logic cks = 1'b0; // Append a check pair when set.
  logic done = 1'b0; // Closing return seen.
  logic [127:0] rep = '0; // Reply body and any check pair, without the return.

  // Lines start idle.
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
    tx_ready = 1'b0;
  end

  // Two upper-case hex characters of the byte sum of a string.
  function automatic string hx(string s);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (s[i]) sum += s[i];
    return $sformatf("%02X", sum);
  endfunction

  // Ready stalls at random, so replies are taken both promptly and slowly.
  always @(posedge clk) begin
    tx_ready <= 1'($random(seed));
    if (tx_valid && tx_ready) begin
      if (tx_data == CH_CR) done <= 1'b1;
      else rep <= {rep[119:0], tx_data};
    end
  end

  // Sends a frame, waits bounded for the reply; bad 1 errs the return, bad 2 spoils the pair.
  task automatic xfer(input string f, input int bad, output logic [127:0] r);
    string s;
    s = f;
    if (cks) s = {f, (bad == 2) ? hx({f, "x"}) : hx(f)};
    s = {s, "\015"};
    rep = '0;
    done = 1'b0;
    foreach (s[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
      rx_err <= (bad == 1) && (i == s.len() - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_err <= 1'b0;
    rx_data <= ~rx_data;
    for (int n = 0; n < 150 && !done; n++) @(posedge clk);
    r = rep;
  endtask
endmodule // host_model

// [verification/tb.sv]
// Self-checking bench of the alarm command handler.
`timescale 1ns/1ns
module tb
  import alarm_pkg::*;
;
  logic MCLK, RSTN, RX_VALID, RX_ERR, TX_VALID, TX_READY, REG_WR, REG_RD;
  logic [7:0] RX_DATA, TX_DATA, DO_OUT, REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  logic [7:0][TEMP_W-1:0] TEMP_IN;
  logic [127:0] r;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 55;
  int c, p;
  string lim, t;
  // Refused frames and their expected answers; an empty answer means silence.
  string bad_f[7] = '{"@01RLC8", "@01LO+001.00C8MO0", "@01LO+001.00C0MO8", "@01RAO8",
                      "@01LO+001,00C0MO0", "@01LO+001.00C0XO0", "@01ZZC0"};
  string bad_e[7] = '{"?01", "?01", "?01", "?01", "", "", "?01"};

  alarm_command_handler alarm_command_handler_i (.MCLK(MCLK), .RSTN(RSTN), .RX_DATA(RX_DATA),
    .RX_VALID(RX_VALID), .RX_ERR(RX_ERR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TEMP_IN(TEMP_IN), .DO_OUT(DO_OUT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
  host_model host_model_i (.clk(MCLK), .rx_data(RX_DATA), .rx_valid(RX_VALID), .rx_err(RX_ERR),
    .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY));

  // Clock of 8 ns.
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // Compares and counts.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Packs a string into characters, last one lowest.
  function automatic logic [127:0] v(string s);
    v = '0;
    foreach (s[i]) v = {v[119:0], s[i]};
  endfunction

  // Sends a frame and compares the reply body, with its check pair when enabled.
  task automatic q(input string f, input int bad, input string e);
    host_model_i.xfer(f, bad, r);
    chk(r, (e == "") ? '0 : v(host_model_i.cks ? {e, host_model_i.hx(e)} : e));
  endtask

  // Register cycles, entered just after an edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= w;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] o);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(posedge MCLK);
    o = REG_RDATA;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  // Main sequence.
  initial begin
    RSTN = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = '0;
    TEMP_IN = '0;
    TEMP_IN[3] = 18'd2000;
    for (int k = 4; k < 8; k++) TEMP_IN[k] = 18'd99999;
    repeat (12) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    // Reset values, unmapped and write-only places.
    rd(R_ADDR, d); chk(d, 32'h01);
    rd(R_CTRL, d); chk(d, 32'h00);
    rd(R_STAT, d); chk(d, 32'h00);
    rd(8'h14, d); chk(d, 32'h00);
    rd(R_HIGH, d); chk(d, 32'h00);
    wr(R_CTRL, 32'h03); rd(R_CTRL, d); chk(d, 32'h03);
    wr(R_CTRL, 32'h00);
    @(posedge MCLK);
    // Own address moved: the old one is ignored, the new one answered.
    wr(R_ADDR, 32'h5a); rd(R_ADDR, d); chk(d, 32'h5a);
    q("@01RLC0", 0, "");
    q("@5ARLC0", 0, "!5A+000.000O0");
    wr(R_ADDR, 32'h01);
    // Random low settings written and read back, both types.
    for (int i = 0; i < 4; i++) begin
      c = 4 + i;
      p = $random(seed) & 1;
      lim = $sformatf("%s%03d.%02d", ($random(seed) & 1) ? "-" : "+", $unsigned($random(seed)) % 1000,
                      $unsigned($random(seed)) % 100);
      t = i[0] ? "L" : "M";
      q($sformatf("@01LO%sC%0d%sO%0d", lim, c, t, p), 0, "!01");
      q($sformatf("@01RLC%0d", c), 0, $sformatf("!01%s%0dO%0d", lim, i[0] + 1, p));
    end
    // Refused frames and a line error.
    foreach (bad_f[k]) q(bad_f[k], 0, bad_e[k]);
    q("@01RLC0", 1, "");
    // Two low alarms and one high alarm share port 5.
    q("@01LO+010.00C3LO5", 0, "!01");
    q("@01LO-005.00C0MO5", 0, "!01");
    wr(R_HIGH, (32'h1 << HI_CH_LSB) | (32'h5 << HI_PRT_LSB) | (32'h1 << HI_TYP_LSB) | 32'h05000);
    q("@01RHC1", 0, "!01+050.001O5");
    TEMP_IN[3] <= 18'd500;
    TEMP_IN[0] <= -18'sd600;
    TEMP_IN[1] <= 18'd6000;
    repeat (5) @(posedge MCLK);
    #1 chk(DO_OUT[5], 1'b1);
    q("@01RAO5", 0, "!010209");
    // Readings recover: only the latched low alarm remains.
    TEMP_IN[3] <= 18'd2000;
    TEMP_IN[0] <= '0;
    TEMP_IN[1] <= '0;
    repeat (5) @(posedge MCLK);
    q("@01RAO5", 0, "!010008");
    wr(R_DOWR, 32'h24);
    repeat (3) @(posedge MCLK);
    #1 chk(DO_OUT, 8'h24);
    q("@01CLC3", 0, "!01");
    repeat (3) @(posedge MCLK);
    #1 chk(DO_OUT, 8'h04);
    // Check pair on frames and replies.
    wr(R_CTRL, 32'h01);
    host_model_i.cks = 1'b1;
    q("@01RLC3", 0, "!01+010.002O5");
    q("@01RLC3", 2, "");
    test_done();
  end
endmodule // tb

bind alarm_command_handler alarm_checker #(.N_DO(N_DO)) alarm_checker_i (.MCLK(MCLK), .RSTN(RSTN),
  .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_ERR(RX_ERR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .DO_OUT(DO_OUT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
